// ===== src/rivm_vector_map.sv
// Reset and interrupt vector address generator.
// Assumes the core fetch logic on sys_clk requests vectors, the fuse is a
// static level from outside the clock domain, and the vector-select bit
// comes from core logic on the same clock.
//
// Operation
// R1: Any system reset starts at word 0x0000 when the boot-reset fuse is unprogrammed.
// R2: External request zero vectors to 0x0002 and external request one to 0x0004 by default.
// R3: Pin change requests zero, one and two vector to 0x0006, 0x0008 and 0x000A.
// R4: The watchdog time-out interrupt vectors to 0x000C by default.
// R5: Timer B match A, match B and overflow vector to 0x000E, 0x0010 and 0x0012.
// R6: Wide timer capture, match A, match B and overflow vector to 0x0014 up to 0x001A.
// R7: Timer A match A, match B and overflow vector to 0x001C, 0x001E and 0x0020.
// R8: The SPI transfer done interrupt vectors to 0x0022.
// R9: USART receive, buffer empty and transmit done vector to 0x0024, 0x0026, 0x0028.
// R10: ADC, EEPROM, comparator, two-wire and self-program vector to 0x002A up to 0x0032.
// R11: A programmed fuse puts the reset entry at 0x0C00 while vectors stay from 0x0002.
// R12: A programmed fuse with the select bit set puts reset and vectors at 0x0C00.
// R13: Software sets the select bit before enabling interrupts; reset stays at 0x000.
// R14: With the select bit set each vector is its default address plus the boot start.
// R15: The first vector sits 0x0002 after the interrupt table's base, relocated or not.
// R16: An address is the table base plus twice the vector number minus one.

`timescale 1ns/1ps
`default_nettype none

module rivm_vector_map #(
    parameter logic [rivm_pkg::ADDR_W-1:0] BOOT_BASE = rivm_pkg::BOOT_START
) (
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    input  wire logic                          boot_reset_fuse,
    input  wire logic                          vector_select_bit,
    input  wire logic                          vec_req,
    input  wire logic [rivm_pkg::NUM_W-1:0]    vec_num,
    output logic                               vec_ready,
    output logic                               vec_ack_q,
    output logic                               vec_bad_q,
    output logic [rivm_pkg::ADDR_W-1:0]        vec_addr_q,
    output logic [rivm_pkg::ADDR_W-1:0]        reset_entry_q,
    output logic                               entry_valid
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The whole relocated table must fit in the address space and start on
    // an even word, since each entry is two words long.
    localparam int TABLE_SPAN = 2 * int'(rivm_pkg::NUM_VECTORS);
    generate
        if (int'(BOOT_BASE) + TABLE_SPAN > (1 << rivm_pkg::ADDR_W))
        begin : g_bad_base
            $error("BOOT_BASE leaves no room for the vector table.");
        end
        if (BOOT_BASE[0] != 1'b0)
        begin : g_odd_base
            $error("BOOT_BASE must be an even word address.");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Fuse synchroniser
    // ------------------------------------------------------------------
    logic                           fuse_s1_q;
    logic                           fuse_s2_q;
    logic                           fuse_s3_q;
    logic                           fuse_q;
    rivm_pkg::rivm_state_type       state_q;
    logic [2:0]                     settle_q;
    logic                           accept;
    logic                           num_bad;
    logic [rivm_pkg::ADDR_W-1:0]    irq_base;
    logic [rivm_pkg::ADDR_W-1:0]    entry_d;
    logic [rivm_pkg::ADDR_W-1:0]    vec_addr_d;

    // Three stages; the stable value follows only when stages two and
    // three agree, so a glitch caught by a single sample never moves the entry.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            fuse_s1_q <= rivm_pkg::FUSE_UNPROG;
            fuse_s2_q <= rivm_pkg::FUSE_UNPROG;
            fuse_s3_q <= rivm_pkg::FUSE_UNPROG;
        end
        else
        begin
            fuse_s1_q <= boot_reset_fuse;
            fuse_s2_q <= fuse_s1_q;
            fuse_s3_q <= fuse_s2_q;
        end
    end

    // Stable fuse level, updated only on agreement.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            fuse_q <= rivm_pkg::FUSE_UNPROG;
        end
        else if (fuse_s2_q == fuse_s3_q)
        begin
            fuse_q <= fuse_s3_q;
        end
    end

    // ------------------------------------------------------------------
    // Start-up sequencing
    // ------------------------------------------------------------------
    // Requests wait until the fuse has passed the synchroniser and the
    // reset entry register holds the value derived from it.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q  <= rivm_pkg::ST_SETTLE;
            settle_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                rivm_pkg::ST_SETTLE:
                begin
                    settle_q <= settle_q + 3'h1;
                    if (settle_q == rivm_pkg::SETTLE_LAST)
                    begin
                        state_q <= rivm_pkg::ST_READY;
                    end
                end
                rivm_pkg::ST_READY:
                begin
                    state_q <= rivm_pkg::ST_READY;
                end
                default:
                begin
                    state_q <= rivm_pkg::ST_SETTLE;
                end
            endcase
        end
    end

    assign vec_ready   = (state_q == rivm_pkg::ST_READY);
    assign entry_valid = vec_ready;
    assign accept      = vec_req && vec_ready;

    // ------------------------------------------------------------------
    // Address computation
    // ------------------------------------------------------------------
    // Reset base follows the fuse alone; the table base follows the select
    // bit alone, so all four fuse and select combinations fall out.
    always_comb
    begin
        entry_d  = (fuse_q == rivm_pkg::FUSE_UNPROG) ?
                   rivm_pkg::APP_BASE : BOOT_BASE;     // see R1 see R11
        irq_base = vector_select_bit ?
                   BOOT_BASE : rivm_pkg::APP_BASE;     // see R12 see R14
        num_bad  = (vec_num == 5'h00) ||
                   ({1'b0, vec_num} > rivm_pkg::NUM_VECTORS);
        if (num_bad || vec_num == rivm_pkg::VEC_RESET)
        begin
            // A bad number falls back to the reset entry, a safe target.
            vec_addr_d = entry_d;
        end
        else                                       // see R8 see R9 see R10
        begin
            // Two words per entry; vector two lands at base plus two.
            vec_addr_d = irq_base + rivm_pkg::ADDR_W'( // see R6 see R7
                {vec_num - 5'h01, 1'b0});              // see R16 see R15
        end
    end

    // Reset entry register, tracking the stable fuse level.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            reset_entry_q <= rivm_pkg::APP_BASE;
        end
        else
        begin
            reset_entry_q <= entry_d;                  // see R1 see R11
        end
    end

    // Answer one edge after an accepted request; address holds until the
    // next one so the fetch logic may sample it late.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            vec_ack_q  <= 1'b0;
            vec_bad_q  <= 1'b0;
            vec_addr_q <= rivm_pkg::APP_BASE;
        end
        else
        begin
            vec_ack_q <= accept;
            if (accept)
            begin
                vec_bad_q  <= num_bad;
                vec_addr_q <= vec_addr_d;  // see R2 see R3 see R4 see R5
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_reset_app;
        @(posedge sys_clk) disable iff (reset)
        entry_valid && fuse_q |-> reset_entry_q == rivm_pkg::APP_BASE;
    endproperty
    a_reset_app: assert property (p_reset_app) // see R1
        else $error("Reset entry not at zero with fuse unprogrammed.");

    property p_ext_zero;
        @(posedge sys_clk) disable iff (reset)
        accept && vec_num == rivm_pkg::VEC_EXT_ZERO && !vector_select_bit
        |=> vec_ack_q && vec_addr_q == rivm_pkg::ADR_EXT_ZERO;
    endproperty
    a_ext_zero: assert property (p_ext_zero) // see R2 see R15
        else $error("External request zero vector wrong.");

    property p_ext_one;
        @(posedge sys_clk) disable iff (reset)
        accept && vec_num == rivm_pkg::VEC_EXT_ONE && !vector_select_bit
        |=> vec_addr_q == rivm_pkg::ADR_EXT_ONE;
    endproperty
    a_ext_one: assert property (p_ext_one) // see R2
        else $error("External request one vector wrong.");

    property p_pin_two;
        @(posedge sys_clk) disable iff (reset)
        accept && vec_num == rivm_pkg::VEC_PIN_TWO && !vector_select_bit
        |=> vec_addr_q == rivm_pkg::ADR_PIN_TWO;
    endproperty
    a_pin_two: assert property (p_pin_two) // see R3
        else $error("Pin change two vector wrong.");

    property p_wdt;
        @(posedge sys_clk) disable iff (reset)
        accept && vec_num == rivm_pkg::VEC_WDT && !vector_select_bit
        |=> vec_addr_q == rivm_pkg::ADR_WDT;
    endproperty
    a_wdt: assert property (p_wdt) // see R4
        else $error("Watchdog vector wrong.");

    property p_timers;
        @(posedge sys_clk) disable iff (reset)
        accept && !vector_select_bit &&
        (vec_num == rivm_pkg::VEC_TB_OVF || vec_num == rivm_pkg::VEC_WT_CAPT
         || vec_num == rivm_pkg::VEC_TA_OVF)
        |=> ($past(vec_num) == rivm_pkg::VEC_TB_OVF
             && vec_addr_q == rivm_pkg::ADR_TB_OVF)
         || ($past(vec_num) == rivm_pkg::VEC_WT_CAPT
             && vec_addr_q == rivm_pkg::ADR_WT_CAPT)
         || ($past(vec_num) == rivm_pkg::VEC_TA_OVF
             && vec_addr_q == rivm_pkg::ADR_TA_OVF);
    endproperty
    a_timers: assert property (p_timers) // see R5 see R6 see R7
        else $error("Timer vector outside its slots.");

    property p_spi_usart;
        @(posedge sys_clk) disable iff (reset)
        accept && !vector_select_bit && vec_num == rivm_pkg::VEC_SPI
        ##1 accept && !vector_select_bit
        && vec_num == rivm_pkg::VEC_USART_TXE
        |-> vec_addr_q == rivm_pkg::ADR_SPI
        ##1 vec_addr_q == rivm_pkg::ADR_USART_TXE;
    endproperty
    a_spi_usart: assert property (p_spi_usart) // see R8 see R9
        else $error("Back-to-back SPI and USART vectors wrong.");

    property p_self_prog;
        @(posedge sys_clk) disable iff (reset)
        accept && vec_num == rivm_pkg::VEC_SELF_PROG
        |=> vec_addr_q == ($past(vector_select_bit) ?
                           BOOT_BASE : rivm_pkg::APP_BASE)
                          + rivm_pkg::ADR_SELF_PROG;
    endproperty
    a_self_prog: assert property (p_self_prog) // see R10 see R14
        else $error("Self-program vector wrong.");

    property p_boot_reset;
        @(posedge sys_clk) disable iff (reset)
        entry_valid && !fuse_q && !vector_select_bit && accept
        && vec_num == rivm_pkg::VEC_EXT_ZERO
        |-> reset_entry_q == BOOT_BASE
        ##1 vec_addr_q == rivm_pkg::ADR_EXT_ZERO;
    endproperty
    a_boot_reset: assert property (p_boot_reset) // see R11
        else $error("Boot reset entry or kept vectors wrong.");

    property p_boot_all;
        @(posedge sys_clk) disable iff (reset)
        !fuse_q && vector_select_bit && accept
        && vec_num == rivm_pkg::VEC_RESET
        |=> vec_addr_q == BOOT_BASE;
    endproperty
    a_boot_all: assert property (p_boot_all) // see R12
        else $error("Relocated reset entry wrong.");

    property p_settle;
        @(posedge sys_clk) disable iff (reset)
        $rose(vec_ready) |-> $past(settle_q) == rivm_pkg::SETTLE_LAST;
    endproperty
    a_settle: assert property (p_settle)
        else $error("Ready rose at the wrong start-up count.");

    c_default_irq: cover property (@(posedge sys_clk) disable iff (reset)
        accept && !vector_select_bit && vec_num == rivm_pkg::VEC_EXT_ZERO);
    c_relocated: cover property (@(posedge sys_clk) disable iff (reset)
        accept && vector_select_bit && vec_num == rivm_pkg::VEC_SELF_PROG);
    c_boot_reset: cover property (@(posedge sys_clk) disable iff (reset)
        entry_valid && !fuse_q);
    c_bad_num: cover property (@(posedge sys_clk) disable iff (reset)
        vec_ack_q && vec_bad_q);

endmodule : rivm_vector_map

`default_nettype wire

// ===== src/rivm_pkg.sv
// Constants for the reset and interrupt vector address generator.
// Assumes word-addressed program memory and two program words per entry.

`default_nettype none

package rivm_pkg;

    // ------------------------------------------------------------------
    // Address space and table shape
    // ------------------------------------------------------------------
    localparam int              ADDR_W        = 13;
    localparam int              NUM_W         = 5;
    localparam logic [5:0]      NUM_VECTORS   = 6'h1a;
    localparam logic [4:0]      VEC_RESET     = 5'h01;
    localparam logic [12:0]     APP_BASE      = 13'h0000;
    localparam logic [12:0]     BOOT_START    = 13'h0c00;
    localparam logic [12:0]     FIRST_IRQ_OFS = 13'h0002;

    // ------------------------------------------------------------------
    // Fuse synchroniser and start-up timing
    // ------------------------------------------------------------------
    localparam logic            FUSE_UNPROG   = 1'b1;
    localparam logic [2:0]      SETTLE_LAST   = 3'h4;

    // ------------------------------------------------------------------
    // Vector numbers of selected sources
    // ------------------------------------------------------------------
    localparam logic [4:0]      VEC_EXT_ZERO  = 5'h02;
    localparam logic [4:0]      VEC_EXT_ONE   = 5'h03;
    localparam logic [4:0]      VEC_PIN_TWO   = 5'h06;
    localparam logic [4:0]      VEC_WDT       = 5'h07;
    localparam logic [4:0]      VEC_TB_OVF    = 5'h0a;
    localparam logic [4:0]      VEC_WT_CAPT   = 5'h0b;
    localparam logic [4:0]      VEC_TA_OVF    = 5'h11;
    localparam logic [4:0]      VEC_SPI       = 5'h12;
    localparam logic [4:0]      VEC_USART_TXE = 5'h14;
    localparam logic [4:0]      VEC_SELF_PROG = 5'h1a;

    // ------------------------------------------------------------------
    // Default word addresses of those sources
    // ------------------------------------------------------------------
    localparam logic [12:0]     ADR_EXT_ZERO  = 13'h0002;
    localparam logic [12:0]     ADR_EXT_ONE   = 13'h0004;
    localparam logic [12:0]     ADR_PIN_TWO   = 13'h000a;
    localparam logic [12:0]     ADR_WDT       = 13'h000c;
    localparam logic [12:0]     ADR_TB_OVF    = 13'h0012;
    localparam logic [12:0]     ADR_WT_CAPT   = 13'h0014;
    localparam logic [12:0]     ADR_TA_OVF    = 13'h0020;
    localparam logic [12:0]     ADR_SPI       = 13'h0022;
    localparam logic [12:0]     ADR_USART_TXE = 13'h0026;
    localparam logic [12:0]     ADR_SELF_PROG = 13'h0032;

    // ------------------------------------------------------------------
    // Start-up state
    // ------------------------------------------------------------------
    typedef enum logic [0:0]
    {
        ST_SETTLE = 1'b0,
        ST_READY  = 1'b1
    } rivm_state_type;

endpackage : rivm_pkg

`default_nettype wire

// ===== dv/rivm_core_model.sv
// Behavioural model of the core fetch logic that asks for vector addresses.
// Assumes the vector map runs on the same sys_clk; the bench calls run().

`timescale 1ns/1ps
`default_nettype none

module rivm_core_model (
    input  wire logic                          sys_clk,
    input  wire logic                          vec_ready,
    input  wire logic                          vec_ack_q,
    input  wire logic                          vec_bad_q,
    input  wire logic [rivm_pkg::ADDR_W-1:0]   vec_addr_q,
    output logic                               vec_req,
    output logic [rivm_pkg::NUM_W-1:0]         vec_num,
    output logic                               vector_select_bit
);

    // ------------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------------
    // Every line has a defined level from time zero.
    initial
    begin
        vec_req           = 1'b0;
        vec_num           = 5'h1f;
        vector_select_bit = 1'b0;
    end

    // ------------------------------------------------------------------
    // Request sequence
    // ------------------------------------------------------------------
    // Each request is held until an edge with vec_ready high takes it, and
    // the answer is read in the following cycle. With skip_wait set the
    // request stands for one edge only, to probe a refusal.
    task automatic run(
        input  logic [4:0]  nums [4],
        input  int          cnt,
        input  logic        sel,
        input  logic        skip_wait,
        output logic [12:0] addrs [4],
        output logic [3:0]  bads,
        output logic [3:0]  acks
    );
        int waits;
        waits = 0;
        bads  = 4'h0;
        acks  = 4'h0;
        @(posedge sys_clk);
        vector_select_bit <= sel;
        vec_req           <= 1'b1;
        vec_num           <= nums[0];
        @(negedge sys_clk);
        for (int i = 0; i < cnt; i++)
        begin
            while (!skip_wait && vec_ready !== 1'b1 && waits < 50)
            begin
                @(negedge sys_clk);
                waits++;
            end
            @(posedge sys_clk);
            if (i + 1 < cnt)
                vec_num <= nums[i + 1];
            else
            begin
                vec_req <= 1'b0;
                vec_num <= ~nums[i];  // No stale number is left behind.
            end
            @(negedge sys_clk);
            acks[i]  = vec_ack_q;
            addrs[i] = vec_addr_q;
            bads[i]  = vec_bad_q;
        end
    endtask : run

endmodule : rivm_core_model

`default_nettype wire

// ===== dv/reset_interrupt_vector_map_tb.sv
// Self-checking bench for the reset and interrupt vector generator.
// Assumes rivm_pkg, the design and the core model are compiled first.

`timescale 1ns/1ps
`default_nettype none

module reset_interrupt_vector_map_tb;

    logic        sys_clk;
    logic        reset;
    logic        boot_reset_fuse;
    logic        vector_select_bit;
    logic        vec_req;
    logic [4:0]  vec_num;
    logic        vec_ready;
    logic        vec_ack_q;
    logic        vec_bad_q;
    logic [12:0] vec_addr_q;
    logic [12:0] reset_entry_q;
    logic        entry_valid;
    int          err_count = 0;
    int          compares = 0;

    // Default placement: vector number beside its word address.
    localparam logic [17:0] ROWS [26] = '{
        {5'h01, 13'h0000}, {5'h02, 13'h0002}, {5'h03, 13'h0004},
        {5'h04, 13'h0006}, {5'h05, 13'h0008}, {5'h06, 13'h000a},
        {5'h07, 13'h000c}, {5'h08, 13'h000e}, {5'h09, 13'h0010},
        {5'h0a, 13'h0012}, {5'h0b, 13'h0014}, {5'h0c, 13'h0016},
        {5'h0d, 13'h0018}, {5'h0e, 13'h001a}, {5'h0f, 13'h001c},
        {5'h10, 13'h001e}, {5'h11, 13'h0020}, {5'h12, 13'h0022},
        {5'h13, 13'h0024}, {5'h14, 13'h0026}, {5'h15, 13'h0028},
        {5'h16, 13'h002a}, {5'h17, 13'h002c}, {5'h18, 13'h002e},
        {5'h19, 13'h0030}, {5'h1a, 13'h0032}};

    // ------------------------------------------------------------------
    // Clock and instances
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    rivm_vector_map i_dut (
        .sys_clk           (sys_clk),
        .reset             (reset),
        .boot_reset_fuse   (boot_reset_fuse),
        .vector_select_bit (vector_select_bit),
        .vec_req           (vec_req),
        .vec_num           (vec_num),
        .vec_ready         (vec_ready),
        .vec_ack_q         (vec_ack_q),
        .vec_bad_q         (vec_bad_q),
        .vec_addr_q        (vec_addr_q),
        .reset_entry_q     (reset_entry_q),
        .entry_valid       (entry_valid)
    );

    rivm_core_model i_core (
        .sys_clk           (sys_clk),
        .vec_ready         (vec_ready),
        .vec_ack_q         (vec_ack_q),
        .vec_bad_q         (vec_bad_q),
        .vec_addr_q        (vec_addr_q),
        .vec_req           (vec_req),
        .vec_num           (vec_num),
        .vector_select_bit (vector_select_bit)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [12:0] exp,
                         input logic [12:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic complete_run;
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // Holds reset for ten cycles with the fuse steady throughout.
    task automatic do_reset(input logic fuse);
        @(posedge sys_clk);
        reset           <= 1'b1;
        boot_reset_fuse <= fuse;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
    endtask : do_reset

    // Counts edges from release until the entry becomes valid.
    task automatic wait_valid(output int n);
        n = 0;
        @(negedge sys_clk);
        while (entry_valid !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_valid

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [12:0] a [4];
        logic [12:0] x [4];
        logic [12:0] base;
        logic [3:0]  b;
        logic [3:0]  k;
        int          n;
        reset           = 1'b1;
        boot_reset_fuse = 1'b1;
        do_reset(1'b1);
        wait_valid(n);
        check("edges to ready", 13'h0005, n[12:0]);
        check("reset entry", 13'h0000, reset_entry_q);
        // Every row in both placements; number 1 never moves here.
        for (int s = 0; s < 2; s++)
        begin
            for (int r = 0; r < 26; r++)
            begin
                i_core.run('{ROWS[r][17:13], 5'h00, 5'h00, 5'h00}, 1,
                           s[0], 1'b0, a, b, k);
                x[0] = ROWS[r][12:0];
                if (s == 1 && r > 0)
                    x[0] = x[0] + 13'h0c00;
                check("vector address", x[0], a[0]);
                check("ack", 13'h0001, {12'h000, k[0]});
                check("bad flag", 13'h0000, {12'h000, b[0]});
            end
        end
        @(negedge sys_clk);
        check("ack after one cycle", 13'h0000, {12'h000, vec_ack_q});
        check("address held", 13'h0c32, vec_addr_q);
        // Back to back, with numbers outside the table second and last.
        i_core.run('{5'h01, 5'h00, 5'h1a, 5'h1b}, 4, 1'b1, 1'b0, a, b, k);
        x = '{13'h0000, 13'h0000, 13'h0c32, 13'h0000};
        for (int i = 0; i < 4; i++)
            check("burst address", x[i], a[i]);
        check("burst acks", 13'h000f, {9'h000, k});
        check("burst bad flags", 13'h000a, {9'h000, b});
        // Back to back in the default table: SPI, USART, then two timers.
        i_core.run('{5'h12, 5'h14, 5'h0b, 5'h0a}, 4, 1'b0, 1'b0, a, b, k);
        x = '{13'h0022, 13'h0026, 13'h0014, 13'h0012};
        for (int i = 0; i < 4; i++)
            check("default burst", x[i], a[i]);
        // Programmed fuse: a request before ready must go unanswered.
        do_reset(1'b0);
        i_core.run('{5'h02, 5'h00, 5'h00, 5'h00}, 1, 1'b0, 1'b1, a, b, k);
        check("early ack", 13'h0000, {12'h000, k[0]});
        wait_valid(n);
        check("boot reset entry", 13'h0c00, reset_entry_q);
        for (int s = 0; s < 2; s++)
        begin
            base = (s == 1) ? 13'h0c00 : 13'h0000;
            i_core.run('{5'h01, 5'h02, 5'h1a, 5'h07}, 4, s[0], 1'b0,
                       a, b, k);
            x = '{13'h0c00, base + 13'h0002, base + 13'h0032,
                  base + 13'h000c};
            for (int i = 0; i < 4; i++)
                check("boot address", x[i], a[i]);
        end
        complete_run();
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    // The tests need well under a thousand cycles; four thousand leaves
    // room for slow answers while still cutting a hang short.
    initial
    begin
        repeat (4000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end

endmodule : reset_interrupt_vector_map_tb

`default_nettype wire
